// ===== rtl/ccp_ctrl_pkg.sv
// What this block does
// - Module enable bit on runs the selected mode; off disables module.
// - Stop-in-idle bit set halts module while device idles.
// - Clock-sync bit synchronises non-system time base clock to system clock.
// - Clock source field picks time base clock; codes 100 and 001 reserved.
// - Prescale field divides time base clock by 1, 4, 16 or 64.
// - Wide time base bit selects 32-bit instead of 16-bit time base.
// - Capture select bit chooses input capture versus compare/PWM/timer.
// - In capture modes the mode field selects the capture edge.
// - In compare modes the mode field selects the output function.
// - Compare code 1111 passes through external input chosen by capture source; code only flags it on externalPass, captureSource unused.
// - Postscaler source picks trigger or period events; ignored in capture.
// - Postscale value N raises interrupt every N+1 events.
// - Capture postscale above 1:4 overflows the capture FIFO.
// - Trigger enable runs triggered time base; retrigger works only with it.
// - One-shot bit enables one-shot trigger lasting one-shot count periods.
// - Alternate sync bit chooses alternate signal as sync output.
// - Sync source field selects sync input, free rollover or none.
// - Auxiliary select 01 picks period rollover; 10, 11 pick mode-dependent signals.
// - Restart enable clears shutdown flag at next period after shutdown ends.
// - Gate mode bit delays shutdown to next time base rollover.
// - Software shutdown bit forces a shutdown event, honouring gate mode.
// - Shutdown source enable bits gate comparators, modules, logic cell, fault.
// - Auxiliary select 00 disables the auxiliary output.
// - Shutdown flag reads one while shutdown holds outputs.
package ccp_ctrl_pkg;
    localparam logic [1:0]  ADDR_CTRL_LOW  = 2'h0;
    localparam logic [1:0]  ADDR_CTRL_HIGH = 2'h1;
    localparam logic [1:0]  ADDR_SHUTDOWN  = 2'h2;
    localparam logic [1:0]  ADDR_STATUS    = 2'h3;
    localparam logic [15:0] CTRL_LOW_RST   = 16'h0000;
    localparam logic [15:0] CTRL_HIGH_RST  = 16'h0000;
    localparam logic [15:0] SHUTDOWN_RST   = 16'h0000;
    localparam logic [15:0] CTRL_LOW_MASK  = 16'hAFFF;
    localparam logic [15:0] CTRL_HIGH_MASK = 16'hCFFF;
    localparam logic [15:0] SHUTDOWN_MASK  = 16'hD0FF;
    localparam int          ENABLE_POS     = 15;
    localparam int          IDLE_STOP_POS  = 13;
    localparam int          CLK_SYNC_POS   = 11;
    localparam int          CLK_SRC_LSB    = 8;
    localparam int          PRESCALE_LSB   = 6;
    localparam int          WIDE_POS       = 5;
    localparam int          CAPTURE_POS    = 4;
    localparam int          POST_SRC_POS   = 15;
    localparam int          RETRIG_POS     = 14;
    localparam int          POSTSCALE_LSB  = 8;
    localparam int          TRIG_EN_POS    = 7;
    localparam int          ONE_SHOT_POS   = 6;
    localparam int          ALT_SYNC_POS   = 5;
    localparam int          RESTART_POS    = 15;
    localparam int          GATE_MODE_POS  = 14;
    localparam int          SW_SHUT_POS    = 12;
    localparam logic [2:0]  CLK_EXT_A      = 3'h7;
    localparam logic [2:0]  CLK_EXT_B      = 3'h6;
    localparam logic [2:0]  CLK_CELL1      = 3'h5;
    localparam logic [2:0]  CLK_LOW_POWER_RC_OSCILLATOR       = 3'h3;
    localparam logic [2:0]  CLK_SOSC       = 3'h2;
    localparam logic [2:0]  CLK_PERIPH     = 3'h0;
    localparam logic [4:0]  SYNC_NONE      = 5'h00;
    localparam logic [4:0]  SYNC_TIMER1    = 5'h0B;
    localparam logic [4:0]  SYNC_CELL1     = 5'h10;
    localparam logic [4:0]  SYNC_CELL2     = 5'h11;
    localparam logic [4:0]  SYNC_CONV      = 5'h1B;
    localparam logic [4:0]  SYNC_FREE      = 5'h1F;
    localparam logic [3:0]  MOD_EXT_INPUT  = 4'hF;
    typedef enum logic [1:0] {AUX_OFF, AUX_ROLL, AUX_EVENT, AUX_SIGNAL} aux_sel_e;
    typedef enum {SD_RUN, SD_ARMED, SD_HELD} shut_state_e;
endpackage

// ===== rtl/ccp_ctrl.sv
`timescale 1ns/1ps
// Control plane of a capture/compare/PWM/timer unit: registers, mode decode,
// time base clock select and prescale, postscaler, sync select, aux output, shutdown.
module ccp_ctrl
    import ccp_ctrl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [1:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic [15:0]      regRdata,
    input  wire logic        idleMode,
    input  wire logic        extClockA,
    input  wire logic        extClockB,
    input  wire logic        cellOneClock,
    input  wire logic        lowPowerRcClock,
    input  wire logic        secondaryOscClock,
    input  wire logic [4:0]  moduleSyncIn,
    input  wire logic        timerOneSync,
    input  wire logic        cellOneOut,
    input  wire logic        cellTwoOut,
    input  wire logic        converterSync,
    input  wire logic        altSyncSignal,
    input  wire logic        periodRollover,
    input  wire logic        triggerOutEvent,
    input  wire logic        captureEvent,
    input  wire logic        compareEvent,
    input  wire logic        compareSignal,
    input  wire logic        specialTrigger,
    input  wire logic        captureDisable,
    input  wire logic [2:0]  captureSource,
    input  wire logic [1:0]  auxiliaryOutputSelect,
    input  wire logic [2:0]  oneShotCountField,
    input  wire logic [6:0]  shutdownSources,
    output logic             moduleRun,
    output logic             timeBaseTick,
    output logic             wideTimeBase,
    output logic             captureMode,
    output logic [3:0]       modeCode,
    output logic             modeReserved,
    output logic             externalPass,
    output logic             interruptPulse,
    output logic             triggerMode,
    output logic             retriggerAllowed,
    output logic             oneShotMode,
    output logic [2:0]       oneShotCount,
    output logic             syncOut,
    output logic             syncSelected,
    output logic             freeRollover,
    output logic             auxOut,
    output logic             shutdownActive
);
    logic [15:0] ctrlLow;
    logic [15:0] ctrlHigh;
    logic [15:0] shutCtrl;
    logic        shutFlag;
    logic        flagClearWrite;
    logic [4:0]  rawClk1;
    logic [4:0]  rawClk2;
    logic        selClk;
    logic        selClkQ;
    logic        clkEdge;
    logic [5:0]  preCount;
    logic [5:0]  preLimit;
    logic [3:0]  postCount;
    logic        postEvent;
    logic        syncSrc;
    logic [6:0]  shutIn1;
    logic [6:0]  shutIn2;
    logic        shutReq;
    logic        auxNext;
    shut_state_e shutState;

    // Bus writes; the status register is flag-only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrlLow  <= CTRL_LOW_RST;
            ctrlHigh <= CTRL_HIGH_RST;
            shutCtrl <= SHUTDOWN_RST;
        end else if (regWrite) begin
            case (regAddr)
                ADDR_CTRL_LOW:  ctrlLow  <= regWdata & CTRL_LOW_MASK;
                ADDR_CTRL_HIGH: ctrlHigh <= regWdata & CTRL_HIGH_MASK;
                ADDR_SHUTDOWN:  shutCtrl <= regWdata & SHUTDOWN_MASK;
                default: ;
            endcase
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdata <= 16'h0000;
        end else if (regRead) begin
            case (regAddr)
                ADDR_CTRL_LOW:  regRdata <= ctrlLow;
                ADDR_CTRL_HIGH: regRdata <= ctrlHigh;
                ADDR_SHUTDOWN:  regRdata <= shutCtrl;
                ADDR_STATUS:    regRdata <= {11'h000, shutFlag, 4'h0};
                default:        regRdata <= 16'h0000;
            endcase
        end else begin
            regRdata <= 16'h0000;
        end
    end

    // Module runs when enabled and not stopped by idle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            moduleRun <= 1'b0;
        end else begin
            moduleRun <= ctrlLow[ENABLE_POS] && !(ctrlLow[IDLE_STOP_POS] && idleMode);
        end
    end

    // Foreign clocks pass two flops; the peripheral clock ticks every cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rawClk1 <= 5'h00;
            rawClk2 <= 5'h00;
            selClkQ <= 1'b0;
        end else begin
            rawClk1 <= {extClockA, extClockB, cellOneClock, lowPowerRcClock, secondaryOscClock};
            rawClk2 <= rawClk1;
            selClkQ <= selClk;
        end
    end

    // Source select; reserved codes give no clock
    always_comb begin
        case (ctrlLow[CLK_SRC_LSB +: 3])
            CLK_EXT_A: selClk = rawClk2[4];
            CLK_EXT_B: selClk = rawClk2[3];
            CLK_CELL1: selClk = rawClk2[2];
            CLK_LOW_POWER_RC_OSCILLATOR:  selClk = rawClk2[1];
            CLK_SOSC:  selClk = rawClk2[0];
            default:   selClk = 1'b0;
        endcase
        if (ctrlLow[CLK_SRC_LSB +: 3] == CLK_PERIPH) begin
            clkEdge = 1'b1;
        end else begin
            // Without sync the async source cannot be sampled safely, so it stays idle
            clkEdge = ctrlLow[CLK_SYNC_POS] && selClk && !selClkQ;
        end
        case (ctrlLow[PRESCALE_LSB +: 2])
            2'h0:    preLimit = 6'h00;
            2'h1:    preLimit = 6'h03;
            2'h2:    preLimit = 6'h0F;
            default: preLimit = 6'h3F;
        endcase
    end

    // Prescaler counts source edges
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            preCount     <= 6'h00;
            timeBaseTick <= 1'b0;
        end else if (!moduleRun) begin
            preCount     <= 6'h00;
            timeBaseTick <= 1'b0;
        end else if (clkEdge) begin
            preCount     <= (preCount >= preLimit) ? 6'h00 : preCount + 6'h01;
            timeBaseTick <= (preCount >= preLimit);
        end else begin
            timeBaseTick <= 1'b0;
        end
    end

    // Mode decode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wideTimeBase <= 1'b0;
            captureMode  <= 1'b0;
            modeCode     <= 4'h0;
            modeReserved <= 1'b0;
            externalPass <= 1'b0;
        end else begin
            wideTimeBase <= ctrlLow[WIDE_POS];
            captureMode  <= ctrlLow[CAPTURE_POS];
            modeCode     <= ctrlLow[3:0];
            // Capture: 011x,1xxx reserved; compare: 10xx,110x,1110 reserved
            modeReserved <= ctrlLow[CAPTURE_POS] ? (ctrlLow[3] || ctrlLow[2:1] == 2'h3)
                          : (ctrlLow[3] && ctrlLow[3:0] != MOD_EXT_INPUT);
            externalPass <= !ctrlLow[CAPTURE_POS] && ctrlLow[3:0] == MOD_EXT_INPUT;
        end
    end

    // Postscaler source; capture always scales capture events
    assign postEvent = ctrlLow[CAPTURE_POS] ? captureEvent
                     : (ctrlHigh[POST_SRC_POS] ? triggerOutEvent : periodRollover);

    // Capture FIFO overflow above 1:4 is software's concern, not guarded here
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            postCount      <= 4'h0;
            interruptPulse <= 1'b0;
        end else if (!moduleRun) begin
            postCount      <= 4'h0;
            interruptPulse <= 1'b0;
        end else if (postEvent) begin
            postCount      <= (postCount >= ctrlHigh[POSTSCALE_LSB +: 4]) ? 4'h0 : postCount + 4'h1;
            interruptPulse <= (postCount >= ctrlHigh[POSTSCALE_LSB +: 4]);
        end else begin
            interruptPulse <= 1'b0;
        end
    end

    // Trigger and one-shot controls
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            triggerMode      <= 1'b0;
            retriggerAllowed <= 1'b0;
            oneShotMode      <= 1'b0;
            oneShotCount     <= 3'h0;
        end else begin
            triggerMode      <= ctrlHigh[TRIG_EN_POS];
            retriggerAllowed <= ctrlHigh[TRIG_EN_POS] && ctrlHigh[RETRIG_POS];
            oneShotMode      <= ctrlHigh[ONE_SHOT_POS];
            oneShotCount     <= ctrlHigh[ONE_SHOT_POS] ? oneShotCountField : 3'h0;
        end
    end

    // Sync input select; remote sources assumed already synchronous
    always_comb begin
        case (ctrlHigh[4:0])
            5'h01:       syncSrc = moduleSyncIn[0];
            5'h02:       syncSrc = moduleSyncIn[1];
            5'h03:       syncSrc = moduleSyncIn[2];
            5'h04:       syncSrc = moduleSyncIn[3];
            5'h05:       syncSrc = moduleSyncIn[4];
            SYNC_TIMER1: syncSrc = timerOneSync;
            SYNC_CELL1:  syncSrc = cellOneOut;
            SYNC_CELL2:  syncSrc = cellTwoOut;
            SYNC_CONV:   syncSrc = converterSync;
            default:     syncSrc = 1'b0;
        endcase
    end

    // Aux output: the select picks the signal, the module family refines it
    always_comb begin
        case (aux_sel_e'(auxiliaryOutputSelect))
            AUX_ROLL:   auxNext = periodRollover;
            AUX_EVENT:  auxNext = ctrlLow[CAPTURE_POS] ? captureDisable
                                : (ctrlLow[3:0] == 4'h0 ? specialTrigger : compareEvent);
            AUX_SIGNAL: auxNext = ctrlLow[CAPTURE_POS] ? captureEvent
                                : (ctrlLow[3:0] != 4'h0 && compareSignal);
            default:    auxNext = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            syncOut      <= 1'b0;
            syncSelected <= 1'b0;
            freeRollover <= 1'b0;
            auxOut       <= 1'b0;
        end else begin
            syncOut      <= ctrlHigh[ALT_SYNC_POS] ? altSyncSignal : periodRollover;
            syncSelected <= moduleRun && syncSrc;
            freeRollover <= ctrlHigh[4:0] == SYNC_FREE;
            auxOut       <= moduleRun && auxNext;
        end
    end

    // Shutdown sources pass two flops, then the enable mask
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shutIn1 <= 7'h00;
            shutIn2 <= 7'h00;
        end else begin
            shutIn1 <= shutdownSources;
            shutIn2 <= shutIn1;
        end
    end
    assign shutReq = |(shutIn2 & shutCtrl[6:0]) || shutCtrl[SW_SHUT_POS];
    assign flagClearWrite = regWrite && regAddr == ADDR_STATUS && !regWdata[4];

    // Shutdown sequencer; a new request beats a software clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shutState <= SD_RUN;
            shutFlag  <= 1'b0;
        end else begin
            case (shutState)
                SD_RUN: begin
                    if (shutReq && (!shutCtrl[GATE_MODE_POS] || periodRollover)) begin
                        shutState <= SD_HELD;
                        shutFlag  <= 1'b1;
                    end else if (shutReq) begin
                        shutState <= SD_ARMED;
                    end
                end
                SD_ARMED: begin
                    if (shutReq && (periodRollover || !shutCtrl[GATE_MODE_POS])) begin
                        shutState <= SD_HELD;
                        shutFlag  <= 1'b1;
                    end else if (!shutReq) begin
                        shutState <= SD_RUN;
                    end
                end
                SD_HELD: begin
                    if (!shutReq && ((shutCtrl[RESTART_POS] && periodRollover) || flagClearWrite)) begin
                        shutState <= SD_RUN;
                        shutFlag  <= 1'b0;
                    end
                end
                default: shutState <= SD_RUN;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shutdownActive <= 1'b0;
        end else begin
            shutdownActive <= moduleRun && shutFlag;
        end
    end

    // Assertions
    a_enable_gates_run: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrlLow[ENABLE_POS] |=> !moduleRun) else $error("run without enable");

    a_idle_stop_halt: assert property (@(posedge clk) disable iff (!rst_n)
        ctrlLow[IDLE_STOP_POS] && idleMode |=> !moduleRun) else $error("ran in idle");

    a_retrig_needs_trig: assert property (@(posedge clk) disable iff (!rst_n)
        retriggerAllowed |-> $past(ctrlHigh[TRIG_EN_POS])) else $error("retrigger without trigger");

    a_ext_pass_decode: assert property (@(posedge clk) disable iff (!rst_n)
        externalPass |-> !captureMode && modeCode == MOD_EXT_INPUT) else $error("bad external mode");

    a_tick_div_one: assert property (@(posedge clk) disable iff (!rst_n)
        moduleRun && $past(moduleRun) && ctrlLow[10:6] == 5'h00 |=> timeBaseTick) else $error("no tick");

    // Shutdown checks
    a_gate_waits_roll: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(shutFlag) && $past(shutCtrl[GATE_MODE_POS]) |-> $past(periodRollover)) else $error("early shutdown");

    a_flag_holds_req: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(shutFlag) |-> !$past(shutReq)) else $error("cleared under request");

    a_shut_at_once: assert property (@(posedge clk) disable iff (!rst_n)
        shutReq && !shutCtrl[GATE_MODE_POS] && !shutFlag |=> shutFlag) else $error("late shutdown");

    // Sync, aux and one-shot checks
    a_free_roll_code: assert property (@(posedge clk) disable iff (!rst_n)
        freeRollover |-> $past(ctrlHigh[4:0]) == SYNC_FREE) else $error("bad free rollover");

    a_sync_alt_select: assert property (@(posedge clk) disable iff (!rst_n)
        ctrlHigh[ALT_SYNC_POS] |=> syncOut == $past(altSyncSignal)) else $error("sync wrong");

    a_aux_off_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        auxiliaryOutputSelect == 2'h0 |=> !auxOut) else $error("aux not off");

    a_aux_roll_copy: assert property (@(posedge clk) disable iff (!rst_n)
        moduleRun && auxiliaryOutputSelect == 2'h1 |=> auxOut == $past(periodRollover)) else $error("aux not roll");

    a_shot_count_field: assert property (@(posedge clk) disable iff (!rst_n)
        ctrlHigh[ONE_SHOT_POS] |=> oneShotCount == $past(oneShotCountField)) else $error("bad one-shot count");

    c_aux_seen: cover property (@(posedge clk) auxOut);
    c_shut_entered: cover property (@(posedge clk) $rose(shutFlag));
    c_interrupt_seen: cover property (@(posedge clk) interruptPulse);
    c_auto_restart: cover property (@(posedge clk) $fell(shutFlag) && shutCtrl[RESTART_POS]);
endmodule // ccp_ctrl

// ===== tb/far_side_model.sv
`timescale 1ns/1ps
// Far-side logic: other timers, logic cells, comparators and the converter.
// Everything is clocked by clk, so the sync sources it offers are synchronous.
module far_side_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        rollOn,
    output logic             roll,
    output logic [15:0]      sig
);
    logic [15:0] cnt;

    // Free-running count; its bits act as clocks, events and sync strobes
    always_ff @(posedge clk) begin
        if (!rst_n) cnt <= 16'h0000;
        else cnt <= cnt + 16'h0001;
    end

    // Sources change only on clk edges, never mid-cycle
    assign sig = cnt;
    // Period rollover every fourth cycle, only while the test asks for it
    assign roll = rollOn && (cnt[1:0] == 2'h3);
endmodule // far_side_model

// ===== tb/capture_compare_pwm_control_tb.sv
`timescale 1ns/1ps
module capture_compare_pwm_control_tb;
    import ccp_ctrl_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic [1:0]  regAddr = 2'h0;
    logic [15:0] regWdata = 16'h0000, regRdata, sig, rd;
    logic        idleMode = 1'b0, rollOn = 1'b0, roll;
    logic [6:0]  shutSrc = 7'h00;
    logic        moduleRun, timeBaseTick, wideTimeBase, captureMode, modeReserved, externalPass;
    logic        interruptPulse, triggerMode, retriggerAllowed, oneShotMode, syncOut;
    logic        freeRollover, shutdownActive, syncSelected, auxOut;
    logic [3:0]  modeCode;
    logic [1:0]  auxiliaryOutputSelect = 2'h0;
    logic [2:0]  oneShotCountField = 3'h0, oneShotCount;
    int          err_count = 0, n_compared = 0, n, m;

    always #4 clk = ~clk;

    far_side_model u_far_side_model (.clk(clk), .rst_n(rst_n), .rollOn(rollOn), .roll(roll), .sig(sig));

    ccp_ctrl u_ccp_ctrl (
        .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .idleMode(idleMode), .extClockA(sig[0]),
        .extClockB(sig[1]), .cellOneClock(sig[2]), .lowPowerRcClock(sig[3]),
        .secondaryOscClock(sig[4]), .moduleSyncIn(sig[9:5]), .timerOneSync(sig[10]),
        .cellOneOut(sig[11]), .cellTwoOut(sig[12]), .converterSync(sig[13]),
        .altSyncSignal(sig[2]), .periodRollover(roll), .triggerOutEvent(sig[3]),
        .captureEvent(sig[1]), .compareEvent(sig[2]), .compareSignal(sig[5]),
        .specialTrigger(sig[6]), .captureDisable(sig[7]), .captureSource(sig[10:8]),
        .shutdownSources(shutSrc), .moduleRun(moduleRun), .timeBaseTick(timeBaseTick),
        .wideTimeBase(wideTimeBase), .captureMode(captureMode), .modeCode(modeCode),
        .modeReserved(modeReserved), .externalPass(externalPass), .interruptPulse(interruptPulse),
        .triggerMode(triggerMode), .retriggerAllowed(retriggerAllowed), .oneShotMode(oneShotMode),
        .oneShotCount(oneShotCount), .syncOut(syncOut), .syncSelected(syncSelected), .freeRollover(freeRollover),
        .auxOut(auxOut), .shutdownActive(shutdownActive), .auxiliaryOutputSelect(auxiliaryOutputSelect),
        .oneShotCountField(oneShotCountField)
    );

    // Register write: one strobe cycle
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        @(posedge clk);
    endtask

    // Register read: data is only valid in the cycle after the strobe
    task automatic rdReg(input logic [1:0] a);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        @(negedge clk);
        rd = regRdata;
        @(posedge clk);
    endtask

    // Value compare with case equality so unknowns never match
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask

    // Event count compare; window edges may cut one event
    task automatic chkCnt(input int got, input int exp, input int tol);
        n_compared++;
        if (got < exp - tol || got > exp + tol) begin
            err_count++;
            $display("Error at %0t: count %0d, expected %0d", $time, got, exp);
        end
    endtask

    // Two sync flops, the flag and the output register need four edges
    task automatic settle();
        repeat (6) @(posedge clk);
    endtask

    task automatic s_registers();
        rdReg(ADDR_CTRL_LOW);  chk(rd, CTRL_LOW_RST);
        rdReg(ADDR_CTRL_HIGH); chk(rd, CTRL_HIGH_RST);
        rdReg(ADDR_SHUTDOWN);  chk(rd, SHUTDOWN_RST);
        rdReg(ADDR_STATUS);    chk(rd, 16'h0000);
        wr(ADDR_CTRL_LOW, 16'hFFFF);
        wr(ADDR_CTRL_HIGH, 16'hFFFF);
        wr(ADDR_SHUTDOWN, 16'hEFFF);
        rdReg(ADDR_CTRL_LOW);  chk(rd, CTRL_LOW_MASK);
        rdReg(ADDR_CTRL_HIGH); chk(rd, CTRL_HIGH_MASK);
        rdReg(ADDR_SHUTDOWN);  chk(rd, 16'hEFFF & SHUTDOWN_MASK);
        wr(ADDR_SHUTDOWN, 16'h0000);
        wr(ADDR_CTRL_HIGH, 16'h0000);
    endtask

    // Enable and idle-stop interplay
    task automatic s_enable();
        wr(ADDR_CTRL_LOW, 16'h8000); settle(); chk(moduleRun, 1'b1);
        idleMode <= 1'b1; settle(); chk(moduleRun, 1'b1);
        wr(ADDR_CTRL_LOW, 16'hA000); settle(); chk(moduleRun, 1'b0);
        idleMode <= 1'b0; settle(); chk(moduleRun, 1'b1);
        wr(ADDR_CTRL_LOW, 16'h0000); settle(); chk(moduleRun, 1'b0);
    endtask

    // Every mode code in both capture and compare families
    task automatic s_modes();
        logic [15:0] e;
        for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < 16; k++) begin
                wr(ADDR_CTRL_LOW, 16'h8000 | 16'(c << 4) | 16'(k) | 16'((k & 1) << 5));
                settle();
                e = {7'h00, c[0], 4'(k), k[0], c ? (k >= 6) : (k >= 8 && k != 15), !c && k == 15};
                chk({7'h00, captureMode, modeCode, wideTimeBase, modeReserved, externalPass}, e);
            end
        end
        for (int i = 0; i < 8; i++) begin
            oneShotCountField <= 3'(7 - i);
            wr(ADDR_CTRL_HIGH, 16'((i & 1) << 7) | 16'((i & 2) << 13) | 16'((i & 4) << 4) | ((i & 4) ? 16'h001F : 16'h0000));
            settle();
            chk({9'h000, oneShotCount, triggerMode, retriggerAllowed, oneShotMode, freeRollover},
                {9'h000, i[2] ? 3'(7 - i) : 3'h0, i[0], i[0] & i[1], i[2], i[2]});
        end
        wr(ADDR_CTRL_HIGH, 16'h0000);
    endtask

    // Prescale on the peripheral clock: ticks in 256 cycles
    task automatic s_prescale();
        for (int p = 0; p < 4; p++) begin
            wr(ADDR_CTRL_LOW, 16'h8000 | 16'(p << 6));
            settle();
            n = 0;
            repeat (256) begin @(posedge clk); n += timeBaseTick; end
            chkCnt(n, 256 >> (2 * p), 1);
        end
    endtask

    // Postscaler counts period events; sync output follows rollover or alternate
    task automatic s_post_sync();
        int ns[4] = '{0, 1, 3, 15};
        wr(ADDR_CTRL_LOW, 16'h8000);
        rollOn <= 1'b1;
        foreach (ns[j]) begin
            wr(ADDR_CTRL_HIGH, 16'(ns[j] << 8));
            settle();
            n = 0;
            repeat (256) begin @(posedge clk); n += interruptPulse; end
            chkCnt(n, 64 / (ns[j] + 1), 1);
        end
        for (int a = 0; a < 3; a++) begin
            wr(ADDR_CTRL_HIGH, (a == 2) ? 16'h0001 : 16'(a << 5));
            settle();
            n = 0; m = 0;
            repeat (64) begin
                @(posedge clk);
                n += (a == 2) ? syncSelected : syncOut;
                m += (a == 2) ? sig[5] : a ? sig[2] : roll;
            end
            chkCnt(n, m, 2);
        end
    endtask

    // Aux output for every select in timer, compare and capture families
    task automatic s_aux();
        for (int f = 0; f < 3; f++) begin
            wr(ADDR_CTRL_LOW, (f == 2) ? 16'h8012 : 16'h8000 | 16'(f));
            for (int s = 0; s < 4; s++) begin
                auxiliaryOutputSelect <= 2'(s);
                settle();
                n = 0;
                m = 0;
                repeat (64) begin
                    @(posedge clk);
                    n += auxOut;
                    m += (s == 1) ? roll : (s == 2) ? sig[(f == 0) ? 6 : (f == 1) ? 2 : 7]
                       : (s == 3 && f > 0) ? sig[(f == 1) ? 5 : 1] : 1'b0;
                end
                chkCnt(n, m, (s == 0 || (s == 3 && f == 0)) ? 0 : 2);
            end
        end
        auxiliaryOutputSelect <= 2'h0;
    endtask

    // Software, gated and source-driven shutdown with automatic restart
    task automatic s_shutdown();
        rollOn <= 1'b1;
        wr(ADDR_SHUTDOWN, 16'h1000); settle(); chk(shutdownActive, 1'b1);
        rdReg(ADDR_STATUS); chk(rd, 16'h0010);
        wr(ADDR_SHUTDOWN, 16'h8000); repeat (12) @(posedge clk); chk(shutdownActive, 1'b0);
        rollOn <= 1'b0;
        wr(ADDR_SHUTDOWN, 16'hD000); repeat (8) @(posedge clk); chk(shutdownActive, 1'b0);
        rollOn <= 1'b1; repeat (8) @(posedge clk); chk(shutdownActive, 1'b1);
        wr(ADDR_SHUTDOWN, 16'h8000); repeat (12) @(posedge clk);
        for (int k = 0; k < 7; k++) begin
            wr(ADDR_SHUTDOWN, 16'h8000 | 16'(1 << k));
            shutSrc <= ~7'(1 << k); settle(); chk(shutdownActive, 1'b0);
            shutSrc <= 7'(1 << k); settle(); chk(shutdownActive, 1'b1);
            shutSrc <= 7'h00; repeat (12) @(posedge clk); chk(shutdownActive, 1'b0);
        end
    endtask

    // Single exit point of the run
    task automatic final_report();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        final_report();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        s_registers();
        s_enable();
        s_modes();
        s_prescale();
        s_post_sync();
        s_aux();
        s_shutdown();
        final_report();
    end
endmodule // capture_compare_pwm_control_tb
